// file: hw/dwc_pkg.sv
// dwc_pkg: shared constants, types and register map of the dma block
//
// What this block does
// - Moves memory-to-peripheral, peripheral-to-memory, memory-to-memory data
// - Memory copy uses paired source and destination channel
// - Register writes alone start a transfer
// - Reload restores setup values and continues
// - Descriptors fetched from memory, next sequence auto-started
// - Linear buffer halts after last element
// - Stride may be positive, negative or zero
// - Circular buffer wraps, event on each full
// - Circular variant flags half or quarter fill
// - Ping-pong ring of link and address descriptors
// - Chained list of four-word descriptors
// - Array of one-word base address descriptors
// - Chained multi-word descriptors supply every parameter
// - Two independent checker instances
// - Signature updated once per 32-bit word
// - Scan mode consumes source words without writing
// - Transfer mode forwards words and folds them
// - Signature mismatch against expected raises fault event
// - Fill writes constant over 1D or 2D block
`default_nettype none

package dwc_pkg;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_SRC     = 8'h04;
	localparam logic [7:0] OFS_DST     = 8'h08;
	localparam logic [7:0] OFS_XCNT    = 8'h0C;
	localparam logic [7:0] OFS_XSTRIDE = 8'h10;
	localparam logic [7:0] OFS_YCNT    = 8'h14;
	localparam logic [7:0] OFS_YSTRIDE = 8'h18;
	localparam logic [7:0] OFS_DPTR    = 8'h1C;
	localparam logic [7:0] OFS_POLY    = 8'h20;
	localparam logic [7:0] OFS_EXPECT  = 8'h24;
	localparam logic [7:0] OFS_CRC0    = 8'h28;
	localparam logic [7:0] OFS_CRC1    = 8'h2C;
	localparam logic [7:0] OFS_STATUS  = 8'h30;

	// ****************************************************************
	// control word field positions
	// ****************************************************************
	localparam int CT_START  = 0;
	localparam int CT_RELOAD = 1;
	localparam int CT_DIR    = 2;  // 2 bits
	localparam int CT_BUF    = 4;  // 2 bits
	localparam int CT_QUART  = 6;
	localparam int CT_DESC   = 8;  // 3 bits
	localparam int CT_CRCOP  = 11; // 3 bits
	localparam int CT_CRCSEL = 14;
	localparam int CT_MIRROR = 15;
	localparam int CT_STOP   = 16;

	// status bits, sticky ones cleared by writing one
	localparam int SB_BUSY  = 0;
	localparam int SB_DONE  = 1;
	localparam int SB_FULL  = 2;
	localparam int SB_FRAC  = 3;
	localparam int SB_FAULT = 4;
	localparam int SB_VERR  = 5;

	// ****************************************************************
	// encodings and reset values
	// ****************************************************************
	localparam logic [1:0] DIR_M2M = 2'h0;
	localparam logic [1:0] DIR_M2P = 2'h1;
	localparam logic [1:0] DIR_P2M = 2'h2;
	localparam logic [1:0] BUF_LIN  = 2'h0;
	localparam logic [1:0] BUF_CIRC = 2'h1;
	localparam logic [1:0] BUF_FRAC = 2'h2;
	localparam logic [2:0] DM_REG   = 3'h0;
	localparam logic [2:0] DM_RING  = 3'h1;
	localparam logic [2:0] DM_LIST1 = 3'h2;
	localparam logic [2:0] DM_ARRAY = 3'h3;
	localparam logic [2:0] DM_LIST2 = 3'h4;
	localparam logic [2:0] OP_NONE  = 3'h0;
	localparam logic [2:0] OP_SCAN  = 3'h1;
	localparam logic [2:0] OP_XFER  = 3'h2;
	localparam logic [2:0] OP_VERI  = 3'h3;
	localparam logic [2:0] OP_FILL  = 3'h4;
	localparam logic [31:0] POLY_RST = 32'h04C11DB7;
	localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} dwc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dwc_axil_rsp_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dwc_mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} dwc_mem_rsp_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_DESC  = 6'b000010,
		ST_READ  = 6'b000100,
		ST_WRITE = 6'b001000,
		ST_STEP  = 6'b010000,
		ST_END   = 6'b100000
	} dwc_state_t;

endpackage

`default_nettype wire

// file: hw/dwc_top.sv
// dwc_top: dma engine with paired channels and two signature checkers
`default_nettype none

module dwc_top import dwc_pkg::*; #(
	parameter int CNT_W = 16
) (
	input  wire logic          ref_clk_i,
	input  wire logic          reset_i,
	input  wire dwc_axil_req_t axi_req_i,
	output var  dwc_axil_rsp_t axi_rsp_o,
	output var  dwc_mem_req_t  mem_req_o,
	input  wire dwc_mem_rsp_t  mem_rsp_i,
	input  wire logic          rx_valid_i,
	input  wire logic [31:0]   rx_data_i,
	output logic               rx_ready_o,
	output logic               tx_valid_o,
	output logic [31:0]        tx_data_o,
	input  wire logic          tx_ready_i,
	output logic               evt_done_o,
	output logic               evt_full_o,
	output logic               evt_frac_o,
	output logic               evt_fault_o,
	output logic               evt_verr_o
);

	if (CNT_W < 2 || CNT_W > 32) begin : g_chk
		$error("CNT_W must lie between 2 and 32");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	// one word into the signature, msb first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [31:0] d, input logic [31:0] p);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[31] ^ d[i]) ? ((r << 1) ^ p) : (r << 1);
		end
		return r;
	endfunction

	// full bit reversal also swaps the byte order
	function automatic logic [31:0] mirror(input logic [31:0] d);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 32; i++) begin
			r[i] = d[31 - i];
		end
		return r;
	endfunction

	function automatic logic [31:0] strb_mrg(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] desc_len(input logic [2:0] m);
		case (m)
			DM_RING:  return 4'h2;
			DM_LIST1: return 4'h4;
			DM_ARRAY: return 4'h1;
			DM_LIST2: return 4'h8;
			default:  return 4'h0;
		endcase
	endfunction

	// ****************************************************************
	// axi4-lite slave
	// ****************************************************************
	dwc_axil_rsp_t rsp_ff;
	logic          aw_have_ff, w_have_ff;
	logic [31:0]   awaddr_ff, wdata_ff;
	logic [3:0]    wstrb_ff;
	logic          nxt_aw_have, nxt_w_have, aw_take, w_take, wr_fire;
	logic          ar_take, wr_map, rd_map;
	logic [31:0]   rd_word;

	logic [31:0] ctrl_ff, src_ff, dst_ff, xstr_ff, ystr_ff, dptr_ff;
	logic [31:0] poly_ff, expect_ff;
	logic [CNT_W-1:0] xcnt_ff, ycnt_ff;
	logic [5:0]  sticky_ff;
	logic [31:0] crc_ff [2];
	dwc_state_t  state_ff;

	// accept address and data in either order, act once both are held
	always_comb begin
		aw_take     = axi_req_i.awvalid & rsp_ff.awready;
		w_take      = axi_req_i.wvalid & rsp_ff.wready;
		wr_fire     = aw_have_ff & w_have_ff & ~rsp_ff.bvalid;
		nxt_aw_have = aw_take | (aw_have_ff & ~wr_fire);
		nxt_w_have  = w_take | (w_have_ff & ~wr_fire);
		ar_take     = axi_req_i.arvalid & rsp_ff.arready;
		wr_map      = (awaddr_ff[31:8] == 24'h0) && (awaddr_ff[1:0] == 2'h0)
			&& (awaddr_ff[7:0] <= OFS_STATUS);
		rd_map      = (axi_req_i.araddr[31:8] == 24'h0)
			&& (axi_req_i.araddr[1:0] == 2'h0)
			&& (axi_req_i.araddr[7:0] <= OFS_STATUS);
	end

	// read mux, unmapped words read zero
	always_comb begin
		case (axi_req_i.araddr[7:0])
			OFS_CTRL:    rd_word = ctrl_ff;
			OFS_SRC:     rd_word = src_ff;
			OFS_DST:     rd_word = dst_ff;
			OFS_XCNT:    rd_word = 32'(xcnt_ff);
			OFS_XSTRIDE: rd_word = xstr_ff;
			OFS_YCNT:    rd_word = 32'(ycnt_ff);
			OFS_YSTRIDE: rd_word = ystr_ff;
			OFS_DPTR:    rd_word = dptr_ff;
			OFS_POLY:    rd_word = poly_ff;
			OFS_EXPECT:  rd_word = expect_ff;
			OFS_CRC0:    rd_word = crc_ff[0];
			OFS_CRC1:    rd_word = crc_ff[1];
			OFS_STATUS:  rd_word = {26'h0, sticky_ff[5:1],
				state_ff != ST_IDLE};
			default:     rd_word = 32'h0;
		endcase
		if (!rd_map) begin
			rd_word = 32'h0;
		end
	end

	// bus handshake registers
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rsp_ff     <= '0;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awaddr_ff  <= 32'h0;
			wdata_ff   <= 32'h0;
			wstrb_ff   <= 4'h0;
		end else begin
			aw_have_ff     <= nxt_aw_have;
			w_have_ff      <= nxt_w_have;
			rsp_ff.awready <= ~nxt_aw_have;
			rsp_ff.wready  <= ~nxt_w_have;
			if (aw_take) begin
				awaddr_ff <= axi_req_i.awaddr;
			end
			if (w_take) begin
				wdata_ff <= axi_req_i.wdata;
				wstrb_ff <= axi_req_i.wstrb;
			end
			if (wr_fire) begin
				rsp_ff.bvalid <= 1'b1;
				rsp_ff.bresp  <= wr_map ? RESP_OK : RESP_ERR;
			end else if (axi_req_i.bready) begin
				rsp_ff.bvalid <= 1'b0;
			end
			if (ar_take) begin
				rsp_ff.rvalid <= 1'b1;
				rsp_ff.rdata  <= rd_word;
				rsp_ff.rresp  <= rd_map ? RESP_OK : RESP_ERR;
			end else if (axi_req_i.rready) begin
				rsp_ff.rvalid <= 1'b0;
			end
			rsp_ff.arready <= ~(ar_take
				| (rsp_ff.rvalid & ~axi_req_i.rready));
		end
	end
	assign axi_rsp_o = rsp_ff;

	// ****************************************************************
	// setup registers; hardware never alters them so reload can reuse
	// ****************************************************************
	logic       wr_ctrl, wr_stat;
	logic [5:0] evt_set;
	assign wr_ctrl = wr_fire && wr_map && awaddr_ff[7:0] == OFS_CTRL;
	assign wr_stat = wr_fire && wr_map && awaddr_ff[7:0] == OFS_STATUS;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_ff   <= 32'h0;
			src_ff    <= 32'h0;
			dst_ff    <= 32'h0;
			xcnt_ff   <= '0;
			xstr_ff   <= 32'h0;
			ycnt_ff   <= '0;
			ystr_ff   <= 32'h0;
			dptr_ff   <= 32'h0;
			poly_ff   <= POLY_RST;
			expect_ff <= 32'h0;
		end else if (wr_fire && wr_map) begin
			case (awaddr_ff[7:0])
				OFS_CTRL:    ctrl_ff <= strb_mrg(ctrl_ff, wdata_ff, wstrb_ff);
				OFS_SRC:     src_ff <= strb_mrg(src_ff, wdata_ff, wstrb_ff);
				OFS_DST:     dst_ff <= strb_mrg(dst_ff, wdata_ff, wstrb_ff);
				OFS_XCNT:    xcnt_ff <= CNT_W'(strb_mrg(32'(xcnt_ff),
					wdata_ff, wstrb_ff));
				OFS_XSTRIDE: xstr_ff <= strb_mrg(xstr_ff, wdata_ff, wstrb_ff);
				OFS_YCNT:    ycnt_ff <= CNT_W'(strb_mrg(32'(ycnt_ff),
					wdata_ff, wstrb_ff));
				OFS_YSTRIDE: ystr_ff <= strb_mrg(ystr_ff, wdata_ff, wstrb_ff);
				OFS_DPTR:    dptr_ff <= strb_mrg(dptr_ff, wdata_ff, wstrb_ff);
				OFS_POLY:    poly_ff <= strb_mrg(poly_ff, wdata_ff, wstrb_ff);
				OFS_EXPECT:  expect_ff <= strb_mrg(expect_ff, wdata_ff,
					wstrb_ff);
				default:     ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// sticky flags: a fresh event beats a same-cycle clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sticky_ff <= 6'h0;
		end else begin
			sticky_ff <= (sticky_ff & ~(wr_stat ? wdata_ff[5:0] : 6'h0))
				| evt_set;
		end
	end
	assign evt_set = {evt_verr_o, evt_fault_o, evt_frac_o, evt_full_o,
		evt_done_o, 1'b0};

	// ****************************************************************
	// transfer engine
	// ****************************************************************
	dwc_mem_req_t     mreq_ff;
	logic [31:0]      cfg_ff, wsrc_ff, wdst_ff, wxstr_ff, wystr_ff;
	logic [31:0]      dnext_ff, link_ff, data_ff;
	logic [CNT_W-1:0] wxlen_ff, xleft_ff, yleft_ff, frac_ff;
	logic [3:0]       didx_ff;
	logic             issued_ff;
	logic             start, src_mem, src_got, dst_wr, seq_cont;
	logic [2:0]       op;
	logic [1:0]       dir;
	logic [31:0]      src_word, fold_word;
	logic [CNT_W-1:0] frac_len;
	logic             csel;

	always_comb begin
		start    = wr_ctrl & wdata_ff[CT_START] & wstrb_ff[0];
		op       = cfg_ff[CT_CRCOP +: 3];
		dir      = cfg_ff[CT_DIR +: 2];
		csel     = cfg_ff[CT_CRCSEL];
		// fill draws on a constant, not on a channel
		src_mem  = (op != OP_FILL) && (dir != DIR_P2M);
		src_word = (op == OP_FILL) ? expect_ff
			: (src_mem ? mem_rsp_i.rdata : rx_data_i);
		src_got  = (op == OP_FILL) | (src_mem ? (mem_rsp_i.ack & mreq_ff.req)
			: (rx_valid_i & rx_ready_o));
		// scan and verify swallow the word, copy needs the write channel
		dst_wr   = (op != OP_SCAN) && (op != OP_VERI);
		fold_word = cfg_ff[CT_MIRROR] ? mirror(src_word) : src_word;
		frac_len = cfg_ff[CT_QUART] ? (wxlen_ff >> 2) : (wxlen_ff >> 1);
		seq_cont = cfg_ff[CT_RELOAD]
			|| (cfg_ff[CT_BUF +: 2] != BUF_LIN);
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_ff    <= ST_IDLE;
			mreq_ff     <= '0;
			cfg_ff      <= 32'h0;
			{wsrc_ff, wdst_ff, wxstr_ff, wystr_ff} <= '0;
			{dnext_ff, link_ff, data_ff} <= '0;
			{wxlen_ff, xleft_ff, yleft_ff, frac_ff} <= '0;
			didx_ff     <= 4'h0;
			issued_ff   <= 1'b0;
			rx_ready_o  <= 1'b0;
			tx_valid_o  <= 1'b0;
			tx_data_o   <= 32'h0;
			crc_ff[0]   <= CRC_SEED;
			crc_ff[1]   <= CRC_SEED;
			{evt_done_o, evt_full_o, evt_frac_o} <= 3'h0;
			{evt_fault_o, evt_verr_o} <= 2'h0;
		end else begin
			{evt_done_o, evt_full_o, evt_frac_o} <= 3'h0;
			{evt_fault_o, evt_verr_o} <= 2'h0;
			case (state_ff)
				// start loads setup values into the working copies
				ST_IDLE: begin
					// an access cut by abort still ends by its own handshake
					if (mem_rsp_i.ack) mreq_ff.req <= 1'b0;
					if (tx_ready_i) tx_valid_o <= 1'b0;
					if (start) begin
						cfg_ff   <= wdata_ff;
						wsrc_ff  <= src_ff;
						wdst_ff  <= dst_ff;
						wxstr_ff <= xstr_ff;
						wystr_ff <= ystr_ff;
						wxlen_ff <= xcnt_ff;
						xleft_ff <= xcnt_ff;
						yleft_ff <= ycnt_ff;
						frac_ff  <= '0;
						dnext_ff <= dptr_ff;
						didx_ff  <= 4'h0;
						crc_ff[wdata_ff[CT_CRCSEL]] <= CRC_SEED;
						state_ff <= (wdata_ff[CT_DESC +: 3] == DM_REG)
							? ST_READ : ST_DESC;
					end
				end
				// one descriptor word per memory read
				ST_DESC: begin
					if (!issued_ff) begin
						mreq_ff   <= '{1'b1, 1'b0, dnext_ff + {26'h0,
							didx_ff, 2'h0}, 32'h0};
						issued_ff <= 1'b1;
					end else if (mem_rsp_i.ack && mreq_ff.req) begin
						mreq_ff.req <= 1'b0;
						issued_ff   <= 1'b0;
						didx_ff     <= didx_ff + 4'h1;
						case (cfg_ff[CT_DESC +: 3])
							DM_RING, DM_LIST1: begin
								case (didx_ff)
									4'h0: link_ff <= mem_rsp_i.rdata;
									4'h1: if (dir == DIR_P2M) wdst_ff <= mem_rsp_i.rdata;
										else wsrc_ff <= mem_rsp_i.rdata;
									4'h2: begin
										wxlen_ff <= CNT_W'(mem_rsp_i.rdata);
										xleft_ff <= CNT_W'(mem_rsp_i.rdata);
									end
									default: cfg_ff <= {mem_rsp_i.rdata[31:11],
										cfg_ff[CT_DESC +: 3], mem_rsp_i.rdata[7:0]};
								endcase
							end
							DM_ARRAY: begin
								link_ff <= dnext_ff + 32'h4;
								if (dir == DIR_P2M) wdst_ff <= mem_rsp_i.rdata;
								else wsrc_ff <= mem_rsp_i.rdata;
							end
							default: begin
								case (didx_ff)
									4'h0: link_ff  <= mem_rsp_i.rdata;
									4'h1: wsrc_ff  <= mem_rsp_i.rdata;
									4'h2: wdst_ff  <= mem_rsp_i.rdata;
									4'h3: begin
										wxlen_ff <= CNT_W'(mem_rsp_i.rdata);
										xleft_ff <= CNT_W'(mem_rsp_i.rdata);
									end
									4'h4: wxstr_ff <= mem_rsp_i.rdata;
									4'h5: yleft_ff <= CNT_W'(mem_rsp_i.rdata);
									4'h6: wystr_ff <= mem_rsp_i.rdata;
									default: cfg_ff <= {mem_rsp_i.rdata[31:11],
										cfg_ff[CT_DESC +: 3], mem_rsp_i.rdata[7:0]};
								endcase
							end
						endcase
						if (didx_ff + 4'h1 == desc_len(cfg_ff[CT_DESC +: 3])) begin
							didx_ff  <= 4'h0;
							// a zero base in the array marks its end
							if (cfg_ff[CT_DESC +: 3] == DM_ARRAY
								&& mem_rsp_i.rdata == 32'h0) begin
								state_ff   <= ST_IDLE;
								evt_done_o <= 1'b1;
							end else begin
								state_ff <= ST_READ;
							end
						end
					end
				end
				// source side: memory read, peripheral word or constant
				ST_READ: begin
					if (!issued_ff) begin
						issued_ff <= 1'b1;
						if (src_mem) begin
							mreq_ff <= '{1'b1, 1'b0, wsrc_ff, 32'h0};
						end else if (op != OP_FILL) begin
							rx_ready_o <= 1'b1;
						end
					end else if (src_got) begin
						issued_ff   <= 1'b0;
						mreq_ff.req <= 1'b0;
						rx_ready_o  <= 1'b0;
						data_ff     <= src_word;
						if (op == OP_SCAN || op == OP_XFER || op == OP_VERI) begin
							crc_ff[csel] <= crc_step(crc_ff[csel], fold_word,
								poly_ff);
						end
						// only the first miscompare raises the error
						if (op == OP_VERI && src_word != expect_ff
							&& !sticky_ff[SB_VERR]) begin
							evt_verr_o <= 1'b1;
						end
						state_ff <= dst_wr ? ST_WRITE : ST_STEP;
					end
				end
				// destination side: memory write or peripheral word
				ST_WRITE: begin
					if (!issued_ff) begin
						issued_ff <= 1'b1;
						if (dir == DIR_M2P && op != OP_FILL) begin
							tx_valid_o <= 1'b1;
							tx_data_o  <= data_ff;
						end else begin
							mreq_ff <= '{1'b1, 1'b1, wdst_ff, data_ff};
						end
					end else if ((tx_valid_o && tx_ready_i)
						|| (mreq_ff.req && mem_rsp_i.ack)) begin
						issued_ff   <= 1'b0;
						tx_valid_o  <= 1'b0;
						mreq_ff.req <= 1'b0;
						state_ff    <= ST_STEP;
					end
				end
				// address walk, row wrap and fill-point events
				ST_STEP: begin
					wsrc_ff  <= wsrc_ff + wxstr_ff;
					wdst_ff  <= wdst_ff + wxstr_ff;
					state_ff <= ST_READ;
					if (cfg_ff[CT_BUF +: 2] == BUF_FRAC && frac_len != '0) begin
						if (frac_ff + 1'b1 == frac_len) begin
							frac_ff    <= '0;
							evt_frac_o <= 1'b1;
						end else begin
							frac_ff <= frac_ff + 1'b1;
						end
					end
					if (xleft_ff <= 1) begin
						if (yleft_ff > 1) begin
							yleft_ff <= yleft_ff - 1'b1;
							xleft_ff <= wxlen_ff;
							wsrc_ff  <= wsrc_ff + wystr_ff;
							wdst_ff  <= wdst_ff + wystr_ff;
						end else begin
							state_ff <= ST_END;
						end
					end else begin
						xleft_ff <= xleft_ff - 1'b1;
					end
				end
				// sequence over: check signature, then chain, wrap or halt
				ST_END: begin
					evt_done_o <= 1'b1;
					crc_ff[csel] <= CRC_SEED;
					if ((op == OP_SCAN || op == OP_XFER)
						&& crc_ff[csel] != expect_ff) begin
						evt_fault_o <= 1'b1;
					end
					if (cfg_ff[CT_DESC +: 3] != DM_REG) begin
						dnext_ff <= link_ff;
						frac_ff  <= '0;
						state_ff <= (link_ff == 32'h0) ? ST_IDLE : ST_DESC;
					end else if (seq_cont) begin
						wsrc_ff  <= src_ff;
						wdst_ff  <= dst_ff;
						xleft_ff <= xcnt_ff;
						yleft_ff <= ycnt_ff;
						wxlen_ff <= xcnt_ff;
						frac_ff  <= '0;
						evt_full_o <= (cfg_ff[CT_BUF +: 2] != BUF_LIN);
						state_ff <= ST_READ;
					end else begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
			// software abort drops any transfer under way
			if (wr_ctrl && wdata_ff[CT_STOP] && state_ff != ST_IDLE) begin
				state_ff    <= ST_IDLE;
				issued_ff   <= 1'b0;
				rx_ready_o  <= 1'b0;
			end
		end
	end
	assign mem_req_o = mreq_ff;

endmodule

`default_nettype wire

// file: dv/dwc_mem_model.sv
// memory partner model: word store answering the engine after a random wait
`default_nettype none

module dwc_mem_model import dwc_pkg::*; (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire dwc_mem_req_t req_i,
	output var  dwc_mem_rsp_t rsp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:1023];
	int          wait_ff;
	// ack is a single pulse; read data scrambled outside it so
	// stale words are never mistaken for a fresh answer
	always @(posedge clk_i) begin
		rsp_o.rdata <= reset_i ? 32'h0 : ~rsp_o.rdata;
		rsp_o.ack   <= 1'b0;
		if (reset_i || rsp_o.ack)
			wait_ff <= $urandom_range(3);
		else if (req_i.req && wait_ff != 0)
			wait_ff <= wait_ff - 1;
		else if (req_i.req) begin
			rsp_o.ack   <= 1'b1;
			rsp_o.rdata <= mem[req_i.addr[11:2]];
			if (req_i.we)
				mem[req_i.addr[11:2]] = req_i.wdata;
		end
	end
endmodule

`default_nettype wire

// file: dv/dwc_top_checker.sv
// checker: handshake and event relations at the dma block's ports
`default_nettype none

module dwc_top_checker import dwc_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic          ref_clk_i,
	input wire logic          reset_i,
	input wire dwc_axil_req_t axi_req_i,
	input wire dwc_axil_rsp_t axi_rsp_o,
	input wire dwc_mem_req_t  mem_req_o,
	input wire dwc_mem_rsp_t  mem_rsp_i,
	input wire logic          rx_valid_i,
	input wire logic          rx_ready_o,
	input wire logic          tx_valid_o,
	input wire logic [31:0]   tx_data_o,
	input wire logic          tx_ready_i,
	input wire logic          evt_done_o,
	input wire logic          evt_fault_o
);
	// ****************************************************************
	// port relations
	// ****************************************************************
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	b_hold_a: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
		|=> axi_rsp_o.bvalid) else $error("bvalid dropped");
	r_answer_a: assert property (axi_req_i.arvalid && axi_rsp_o.arready
		|=> axi_rsp_o.rvalid) else $error("read late");
	r_hold_a: assert property (axi_rsp_o.rvalid && !axi_req_i.rready
		|=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
		else $error("rdata moved");
	ar_block_a: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
		else $error("arready while busy");
	mem_hold_a: assert property (mem_req_o.req && !mem_rsp_i.ack
		|=> mem_req_o.req && $stable(mem_req_o.addr))
		else $error("memory request moved");
	mem_drop_a: assert property (mem_req_o.req && mem_rsp_i.ack
		|=> !mem_req_o.req) else $error("memory req kept");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i
		|=> tx_valid_o && $stable(tx_data_o))
		else $error("tx word moved");
	rx_take_a: assert property (rx_ready_o && rx_valid_i |=> !rx_ready_o)
		else $error("rx ready kept");
	fault_pulse_a: assert property (evt_fault_o |=> !evt_fault_o)
		else $error("fault not a pulse");
	// main scenarios reached
	done_c: cover property (evt_done_o);
	fault_c: cover property (evt_fault_o);
	rx_c: cover property (rx_ready_o && rx_valid_i);
endmodule

bind dwc_top dwc_top_checker #(.CNT_W(CNT_W)) chk_u (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o), .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i),
	.rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
	.tx_ready_i(tx_ready_i), .evt_done_o(evt_done_o),
	.evt_fault_o(evt_fault_o));

`default_nettype wire

// file: dv/dma_with_crc_checker_tb.sv
// bench: register tasks, stream partners, copy, fill and signature runs
`default_nettype none

module dma_with_crc_checker_tb import dwc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk = 0, rst = 1, rxv = 0, txr = 0;
	logic [31:0]   rxd = 0, v, crc, txd;
	logic [1:0]    r;
	logic          rxr, txv, dn, fa;
	dwc_axil_req_t rq = '0;
	dwc_axil_rsp_t rs;
	dwc_mem_req_t  mq;
	dwc_mem_rsp_t  ms;
	logic [31:0]   rxq[$], txq[$];
	int            mismatches = 0, checks_done = 0, cyc = 0;
	always #5 clk = ~clk;
	dwc_top dut_u (.ref_clk_i(clk), .reset_i(rst), .axi_req_i(rq),
		.axi_rsp_o(rs), .mem_req_o(mq), .mem_rsp_i(ms), .rx_valid_i(rxv),
		.rx_data_i(rxd), .rx_ready_o(rxr), .tx_valid_o(txv),
		.tx_data_o(txd), .tx_ready_i(txr), .evt_done_o(dn),
		.evt_full_o(), .evt_frac_o(), .evt_fault_o(fa), .evt_verr_o());
	dwc_mem_model mem_u (.clk_i(clk), .reset_i(rst), .req_i(mq),
		.rsp_o(ms));
	// ****************************************************************
	// stream partners stall at random; takes are recorded
	// ****************************************************************
	always @(posedge clk) begin
		if (rxr && rxv) begin
			rxq.push_back(rxd);
			rxd <= $urandom;
		end
		if (txv && txr)
			txq.push_back(txd);
		rxv <= 1'($urandom_range(1));
		txr <= 1'($urandom_range(1));
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// bus master: payload held until its own ready, bready kept high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		rq.awvalid <= 1'b1;
		rq.awaddr  <= {24'h0, a};
		rq.wvalid  <= 1'b1;
		rq.wdata   <= d;
		rq.wstrb   <= 4'hF;
		rq.bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (rs.awready) rq.awvalid <= 1'b0;
			if (rs.wready) rq.wvalid <= 1'b0;
		end while (rs.bvalid !== 1'b1);
		r = rs.bresp;
		rq.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		rq.arvalid <= 1'b1;
		rq.araddr  <= {24'h0, a};
		rq.rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (rs.arready) rq.arvalid <= 1'b0;
		end while (rs.rvalid !== 1'b1);
		v = rs.rdata;
		r = rs.rresp;
		rq.rready <= 1'b0;
	endtask
	task automatic setup(input logic [31:0] s, d, n, st);
		wr(OFS_SRC, s);
		wr(OFS_DST, d);
		wr(OFS_XCNT, n);
		wr(OFS_XSTRIDE, st);
	endtask
	// start by register write alone, then wait for the done pulse
	task automatic run(input logic [31:0] c);
		int n;
		n = 0;
		wr(OFS_CTRL, c);
		while (dn !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, dn}, 32'h1);
	endtask
	function automatic logic [31:0] crc_w(logic [31:0] c, logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? POLY_RST : 32'h0);
		return c;
	endfunction
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'hB26DD905));
		for (int i = 0; i < 1024; i++)
			mem_u.mem[i] = (i >= 64 && i < 72) ? $urandom : 32'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_POLY);
		chk(v, POLY_RST);
		rd(OFS_CRC0);
		chk(v, CRC_SEED);
		wr(8'h40, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_ERR});
		setup(32'h100, 32'h200, 4, 32'h4);
		run(32'h1);
		for (int i = 0; i < 5; i++)
			chk(mem_u.mem[128+i], i < 4 ? mem_u.mem[64+i] : 32'h0);
		setup(32'h11C, 32'h31C, 4, 32'hFFFFFFFC);
		run(32'h1);
		for (int i = 0; i < 5; i++)
			chk(mem_u.mem[195+i], i > 0 ? mem_u.mem[67+i] : 32'h0);
		setup(32'h0, 32'h400, 3, 32'h4);
		wr(OFS_EXPECT, 32'hA5A50FF0);
		run(32'h1 | 32'(OP_FILL) << 11);
		for (int i = 0; i < 4; i++)
			chk(mem_u.mem[256+i], i < 3 ? 32'hA5A50FF0 : 32'h0);
		crc = CRC_SEED;
		for (int i = 0; i < 4; i++)
			crc = crc_w(crc, mem_u.mem[64+i]);
		setup(32'h100, 32'h800, 4, 32'h4);
		wr(OFS_EXPECT, crc);
		run(32'h1 | 32'(OP_SCAN) << 11);
		rd(OFS_STATUS);
		chk({31'h0, v[SB_FAULT]}, 32'h0);
		chk(mem_u.mem[512], 32'h0);
		wr(OFS_EXPECT, crc ^ 32'h1);
		run(32'h4001 | 32'(OP_SCAN) << 11);
		rd(OFS_STATUS);
		chk({31'h0, v[SB_FAULT]}, 32'h1);
		wr(OFS_STATUS, 32'h3E);
		wr(OFS_EXPECT, crc);
		// mirrored folding must move the signature off crc
		run(32'h8001 | 32'(OP_XFER) << 11);
		rd(OFS_STATUS);
		chk({31'h0, v[SB_FAULT]}, 32'h1);
		for (int i = 0; i < 4; i++)
			chk(mem_u.mem[512+i], mem_u.mem[64+i]);
		run(32'h1 | 32'(OP_VERI) << 11);
		rd(OFS_STATUS);
		chk({31'h0, v[SB_VERR]}, 32'h1);
		// fractional ring runs on after done until stopped
		wr(OFS_STATUS, 32'h3E);
		run(32'h1 | 32'(BUF_FRAC) << 4);
		rd(OFS_STATUS);
		chk(v, 32'hF);
		wr(OFS_CTRL, 32'h10000);
		rxq.delete();
		setup(32'h0, 32'h600, 4, 32'h4);
		run(32'h1 | 32'(DIR_P2M) << 2);
		for (int i = 0; i < 4; i++)
			chk(mem_u.mem[384+i], rxq[i]);
		setup(32'h100, 32'h0, 4, 32'h4);
		run(32'h1 | 32'(DIR_M2P) << 2);
		for (int i = 0; i < 4; i++)
			chk(txq[i], mem_u.mem[64+i]);
		print_verdict();
	end
endmodule

`default_nettype wire
